/* File: rtl/boot_ctrl_pkg.sv */
// Purpose: Shared constants and carriers for the global control sequencer
// Assumes: One 100 MHz clock
// Notes: Release cycle of the start-up phase is a package constant
package boot_ctrl_pkg;
   localparam logic [2:0] RELEASE_STEP = 3'h4;
   localparam logic [2:0] LAST_STEP = 3'h6;
   localparam logic RESET_INIT = 1'b1;
   localparam logic FLOAT_INIT = 1'b1;

   typedef enum logic [1:0]
   {
      ST_CONFIG = 2'b00,
      ST_BOOT_PHASE_PRIMITIVE = 2'b01,
      ST_USER = 2'b10
   } phase_e;

   // User-side sources wired to the boot phase primitive
   typedef struct packed
   {
      logic initConnected;
      logic initSrc;
      logic floatConnected;
      logic floatSrc;
   } user_src_s;

   // Global control outputs
   typedef struct packed
   {
      logic globalInitAllFlops;
      logic globalFloatAllPins;
   } global_ctrl_s;
endpackage

/* File: rtl/global_set_reset_tristate_ctrl.sv */
// Purpose: Global init and float controls through configuration and start-up
// Assumes: Single clk; user sources and trigger arrive asynchronously
// Notes: Outputs registered; start-up steps on clk or an alternate step pulse
//
// What this block does
// - Init high forces every flop to initial value
// - Float high tri-states every pin driver
// - Init asserted throughout configuration automatically
// - Both held active all of configuration
// - Both released on chosen start-up cycle
// - After start-up, follow connected user sources
// - Alternate clock may step the start-up
// - Trigger input requests alternate image reload
`timescale 1ns/1ps
module global_set_reset_tristate_ctrl
   import boot_ctrl_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, low active
   input wire logic configDone, // Configuration load finished, async
   input wire logic useAltStepClk, // Step start-up on alternate clock
   input wire logic altStepClk, // Alternate start-up clock, async
   input wire boot_ctrl_pkg::user_src_s userSrc, // User sources, async
   input wire logic altImageReloadTrigger, // Reload request, async
   output boot_ctrl_pkg::global_ctrl_s globalCtrl, // Registered controls
   output logic reloadRequest, // One-cycle reload pulse
   output logic startupDone // High once in user phase
);
   import boot_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   logic [7:0] syncIn;
   logic doneSync;
   logic altModeSync;
   logic altClkSync;
   logic trigSync;
   user_src_s srcSync;

   sync_two_ff #(.WIDTH(8)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din({configDone, useAltStepClk, altStepClk,
            altImageReloadTrigger, userSrc}),
      .dout(syncIn)
   );

   always_comb
   begin
      doneSync = syncIn[7];
      altModeSync = syncIn[6];
      altClkSync = syncIn[5];
      trigSync = syncIn[4];
      srcSync = user_src_s'(syncIn[3:0]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised levels
   logic altClkPrev_q;
   logic altClkPrev_d;
   logic trigPrev_q;
   logic trigPrev_d;
   logic stepEn;
   logic trigRise;

   always_comb
   begin
      altClkPrev_d = altClkSync;
      trigPrev_d = trigSync;
      // Step on every clk, or on rising edges of the alternate clock
      stepEn = altModeSync ? (altClkSync & ~altClkPrev_q) : 1'b1;
      trigRise = trigSync & ~trigPrev_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         altClkPrev_q <= 1'b0;
         trigPrev_q <= 1'b0;
      end
      else
      begin
         altClkPrev_q <= altClkPrev_d;
         trigPrev_q <= trigPrev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer
   phase_e phase_q;
   phase_e phase_d;
   logic [2:0] step_q;
   logic [2:0] step_d;
   global_ctrl_s ctrl_q;
   global_ctrl_s ctrl_d;
   logic reload_q;
   logic reload_d;
   logic done_q;
   logic done_d;

   always_comb
   begin
      phase_d = phase_q;
      step_d = step_q;
      ctrl_d = ctrl_q;
      reload_d = 1'b0;
      done_d = done_q;
      case (phase_q)
         ST_CONFIG:
         begin
            // Controls held regardless of user sources
            ctrl_d.globalInitAllFlops = 1'b1;
            ctrl_d.globalFloatAllPins = 1'b1;
            step_d = 3'h0;
            done_d = 1'b0;
            if (doneSync)
            begin
               phase_d = ST_BOOT_PHASE_PRIMITIVE;
            end
         end
         ST_BOOT_PHASE_PRIMITIVE:
         begin
            if (stepEn)
            begin
               step_d = step_q + 3'h1;
               if (step_q == RELEASE_STEP)
               begin
                  ctrl_d.globalInitAllFlops = 1'b0;
                  ctrl_d.globalFloatAllPins = 1'b0;
               end
               if (step_q == LAST_STEP)
               begin
                  phase_d = ST_USER;
                  done_d = 1'b1;
               end
            end
         end
         ST_USER:
         begin
            // Unconnected sources leave the control released
            ctrl_d.globalInitAllFlops =
               srcSync.initConnected & srcSync.initSrc;
            ctrl_d.globalFloatAllPins =
               srcSync.floatConnected & srcSync.floatSrc;
            if (trigRise)
            begin
               reload_d = 1'b1;
               phase_d = ST_CONFIG;
               done_d = 1'b0;
               ctrl_d.globalInitAllFlops = 1'b1;
               ctrl_d.globalFloatAllPins = 1'b1;
            end
         end
         default:
         begin
            phase_d = ST_CONFIG;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= ST_CONFIG;
         step_q <= 3'h0;
         ctrl_q.globalInitAllFlops <= RESET_INIT;
         ctrl_q.globalFloatAllPins <= FLOAT_INIT;
         reload_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         step_q <= step_d;
         ctrl_q <= ctrl_d;
         reload_q <= reload_d;
         done_q <= done_d;
      end
   end

   assign globalCtrl = ctrl_q;
   assign reloadRequest = reload_q;
   assign startupDone = done_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence releaseStep_s;
      phase_q == ST_BOOT_PHASE_PRIMITIVE && stepEn && step_q == RELEASE_STEP;
   endsequence

   sequence bothReleased_s;
      !ctrl_q.globalInitAllFlops && !ctrl_q.globalFloatAllPins;
   endsequence

   config_init_held_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      phase_q == ST_CONFIG |-> ctrl_q.globalInitAllFlops)
      else $error("init not held in configuration");

   config_float_held_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_CONFIG && $past(phase_q) == ST_CONFIG)
      |-> ctrl_q.globalFloatAllPins && ctrl_q.globalInitAllFlops)
      else $error("controls dropped during configuration");

   boot_phase_primitive_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      releaseStep_s |=> bothReleased_s)
      else $error("controls not released on chosen step");

   no_early_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_BOOT_PHASE_PRIMITIVE && step_q < RELEASE_STEP)
      |-> ctrl_q.globalInitAllFlops && ctrl_q.globalFloatAllPins)
      else $error("controls released too early");

   user_init_follow_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_USER && !trigRise) |=>
      ctrl_q.globalInitAllFlops ==
      $past(srcSync.initConnected & srcSync.initSrc))
      else $error("init does not follow user source");

   unconnected_low_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_USER && !srcSync.floatConnected && !trigRise)
      |=> !ctrl_q.globalFloatAllPins)
      else $error("unconnected float control asserted");

   alt_step_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_BOOT_PHASE_PRIMITIVE && !stepEn) |=> $stable(step_q))
      else $error("start-up stepped without alternate edge");

   reload_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (phase_q == ST_USER && trigRise) |=>
      reloadRequest && phase_q == ST_CONFIG ##1 !reloadRequest)
      else $error("reload trigger mishandled");
endmodule

/* File: rtl/sync_two_ff.sv */
// Purpose: Two-stage synchroniser for a bundle of levels
// Assumes: Inputs asynchronous to clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
)
(
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset
   input wire logic [WIDTH-1:0] din, // Async levels
   output logic [WIDTH-1:0] dout // Synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule

/* File: verification/global_set_reset_tristate_ctrl_tb.sv */
// Purpose: Self-checking bench for the global control sequencer
// Assumes: 100 MHz clk, inputs driven 1 ns after rising edge
// Notes: Reset held 6 cycles
`timescale 1ns/1ps
module global_set_reset_tristate_ctrl_tb;
   import boot_ctrl_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic configDone = 1'b0;
   logic useAltStepClk = 1'b0;
   logic altRun = 1'b0;
   logic trigReq = 1'b0;
   user_src_s srcReq = 4'h5;
   user_src_s userSrc;
   global_ctrl_s globalCtrl;
   logic altStepClk, trigger, reloadRequest, startupDone;
   int errorCnt = 0;
   int nChecks = 0;

   always #5 clk = ~clk;

   user_logic_model peer (.clk(clk), .altRun(altRun), .srcReq(srcReq),
      .trigReq(trigReq), .userSrc(userSrc), .altStepClk(altStepClk),
      .trigger(trigger));

   global_set_reset_tristate_ctrl dut (.clk(clk), .rst_n(rst_n),
      .configDone(configDone), .useAltStepClk(useAltStepClk),
      .altStepClk(altStepClk), .userSrc(userSrc),
      .altImageReloadTrigger(trigger), .globalCtrl(globalCtrl),
      .reloadRequest(reloadRequest), .startupDone(startupDone));

   ////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stopTest;
      $display("checks=%0d errors=%0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Held during reset and configuration, sources ignored
   task automatic config_hold;
      step(6);
      chk({2'h0, globalCtrl}, 4'h3);
      rst_n = 1'b1;
      srcReq = 4'hA;
      repeat (10)
      begin
         step(1);
         chk({startupDone, 1'b0, globalCtrl}, 4'h3);
      end
      srcReq = 4'h5;
   endtask

   // Release on the chosen start-up step, then unconnected stays low
   task automatic boot_phase_primitive_release;
      configDone = 1'b1;
      step(7);
      chk({2'h0, globalCtrl}, 4'h3);
      step(1);
      chk({2'h0, globalCtrl}, 4'h0);
      step(2);
      chk({3'h0, startupDone}, 4'h1);
      repeat (8)
      begin
         step(1);
         chk({2'h0, globalCtrl}, 4'h0);
      end
   endtask

   // Controls follow connected sources three edges later
   task automatic user_follow;
      logic [1:0] prev;
      prev = 2'h0;
      for (int v = 1; v < 5; v++)
      begin
         srcReq = {1'b1, v[1], 1'b1, v[0]};
         step(2);
         chk({2'h0, globalCtrl}, {2'h0, prev});
         step(1);
         chk({2'h0, globalCtrl}, {2'h0, v[1:0]});
         prev = v[1:0];
      end
   endtask

   // Trigger gives one reload pulse and back to configuration
   task automatic reload;
      srcReq = 4'h5;
      configDone = 1'b0;
      step(4);
      trigReq = 1'b1;
      step(2);
      chk({3'h0, reloadRequest}, 4'h0);
      step(1);
      chk({reloadRequest, startupDone, globalCtrl}, 4'hB);
      step(1);
      chk({reloadRequest, startupDone, globalCtrl}, 4'h3);
      trigReq = 1'b0;
   endtask

   // Start-up stepped by the slow alternate clock
   task automatic alt_step;
      int i;
      useAltStepClk = 1'b1;
      altRun = 1'b1;
      configDone = 1'b1;
      step(20);
      chk({startupDone, 1'b0, globalCtrl}, 4'h3);
      for (i = 0; i < 120 && startupDone !== 1'b1; i++)
         step(1);
      chk({startupDone, 1'b0, globalCtrl}, 4'h8);
      altRun = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      #20000;
      errorCnt++;
      stopTest();
   end

   initial
   begin
      config_hold();
      boot_phase_primitive_release();
      user_follow();
      reload();
      alt_step();
      stopTest();
   end
endmodule

/* File: verification/user_logic_model.sv */
// Purpose: Far-side user logic feeding sources, trigger and alternate clock
// Assumes: Requests come from the bench just after a clk edge
// Notes: Alternate clock stands low while not running
`timescale 1ns/1ps
module user_logic_model
   import boot_ctrl_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic altRun, // Run alternate clock
   input wire boot_ctrl_pkg::user_src_s srcReq, // Wanted sources
   input wire logic trigReq, // Wanted reload
   output boot_ctrl_pkg::user_src_s userSrc, // Sources to block
   output logic altStepClk, // Alternate start-up clock
   output logic trigger // Reload trigger
);
   logic [2:0] div_q = 3'h0;
   logic altClk_q = 1'b0;
   assign userSrc = srcReq;
   assign trigger = trigReq;
   assign altStepClk = altClk_q;
   // Eight clk period, four clk per phase
   always @(posedge clk)
   begin
      div_q <= altRun ? div_q + 3'h1 : 3'h0;
      altClk_q <= altRun & div_q[2];
   end
endmodule
